// >>> hw/vtc_pkg.sv
// What this block does
// R1: Accept video from two input links.
// R2: Single-link: only the selected link reaches texture memory.
// R3: Dual-link: colour from first link, alpha from second.
// R4: Alternation flips selected link after each completed capture.
// R5: Crop subregion, decimate horizontally and vertically independently.
// R6: Write only on request; otherwise discard data.
// R7: Acknowledge request at once; transfer runs in background.
// R8: Single buffer: consumer waits for load before reading.
// R9: Requester alternates captures between two texture buffers.
// R10: Double buffering needs at least 4 MB texture memory.
// R11: Pyramid mode writes every level per capture.
// R12: Level zero 512x256, halving down to 1x1.
// R13: Pyramid ratios: 512/width, 256/max(256,height), decimation one.
// R14: Capture starts next field; one-field buffer delay.
// R15: Raise done event and missed event.
// R16: Busy while capturing; ignore requests until done.
package vtc_pkg;
    localparam int LVL0_W = 512;
    localparam int LVL0_H = 256;
    localparam int LVL_COUNT = 10;
    localparam int XW = 9;
    localparam int YW = 8;
    localparam int LW = 4;
    localparam int CW = 12;
    localparam int RW = 12;
    localparam int DW = 8;
    localparam int PXW = 32;
    localparam int ALPHA_W = 8;
    localparam int ACW = 21;
    localparam longint TEX_MEM_MIN_BYTES = 64'h0000_0000_0040_0000;

    typedef struct packed {
        logic link_sel;
        logic alt_en;
        logic dual;
        logic pyramid;
        logic [DW-1:0] dec_num;
        logic [DW-1:0] dec_den;
        logic [RW-1:0] h_num;
        logic [RW-1:0] h_den;
        logic [RW-1:0] v_num;
        logic [RW-1:0] v_den;
        logic [CW-1:0] off_x;
        logic [CW-1:0] off_y;
        logic [CW-1:0] size_w;
        logic [CW-1:0] size_h;
    } vtc_cfg_t;

    localparam vtc_cfg_t CFG_RST = '{1'b0, 1'b0, 1'b0, 1'b0, 8'h01, 8'h01, 12'h001, 12'h001,
        12'h001, 12'h001, 12'h000, 12'h000, 12'h200, 12'h100};
endpackage

// >>> hw/vtc_if.sv
`timescale 1ns/1ns
`default_nettype none
interface vtc_if;
    import vtc_pkg::*;
    logic req;
    logic req_buf;
    vtc_cfg_t cfg;
    logic ack;
    logic busy;
    logic done_ev;
    logic missed_ev;
    logic cur_link;
    logic tm_valid;
    logic tm_ready;
    logic tm_buf;
    logic [LW-1:0] tm_level;
    logic [XW-1:0] tm_x;
    logic [YW-1:0] tm_y;
    logic [PXW-1:0] tm_data;

    modport dev(input req, req_buf, cfg, tm_ready,
        output ack, busy, done_ev, missed_ev, cur_link, tm_valid, tm_buf, tm_level, tm_x, tm_y, tm_data);
    modport host(output req, req_buf, cfg, tm_ready,
        input ack, busy, done_ev, missed_ev, cur_link, tm_valid, tm_buf, tm_level, tm_x, tm_y, tm_data);
endinterface
`default_nettype wire

// >>> hw/vtc_dev.sv
`timescale 1ns/1ns
`default_nettype none
module vtc_dev import vtc_pkg::*; #(
    parameter int BUF_W = LVL0_W,
    parameter int BUF_H = LVL0_H,
    parameter int LEVELS = LVL_COUNT
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    vtc_if.dev lnk,
    input wire logic a_valid_i,
    input wire logic a_fs_i,
    input wire logic a_ls_i,
    input wire logic [PXW-1:0] a_data_i,
    input wire logic b_valid_i,
    input wire logic b_fs_i,
    input wire logic b_ls_i,
    input wire logic [PXW-1:0] b_data_i
);
    typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_FILL, ST_DRAIN} vtc_state_t;

    vtc_state_t st_q;
    vtc_state_t st_d;
    vtc_cfg_t cfg_q;
    logic ack_q;
    logic busy_q;
    logic done_q;
    logic missed_q;
    logic cur_link_q;
    logic buf_q;
    logic tmv_q;
    logic last_q;
    logic [LW-1:0] lvl_q;
    logic [XW-1:0] dx_q;
    logic [YW-1:0] dy_q;
    logic [LW-1:0] tm_lvl_q;
    logic [XW-1:0] tm_x_q;
    logic [YW-1:0] tm_y_q;
    logic [PXW-1:0] tm_data_q;
    logic [CW-1:0] rx_q;
    logic [CW-1:0] ry_q;
    logic [CW-1:0] ox_q;
    logic [CW-1:0] oy_q;
    logic [CW-1:0] nline_q;
    logic line_ok_q;
    logic [ACW-1:0] hacc_q;
    logic [ACW-1:0] vacc_q;
    // The whole cropped, decimated capture is held here so that it can be replayed once per level.
    logic [PXW-1:0] fbuf [BUF_W*BUF_H];
    // Rows are packed at the buffer's own width so that a shrunk buffer still holds every line.
    localparam int AXW = $clog2(BUF_W);
    localparam int AYW = $clog2(BUF_H);

    // Requests are refused, not queued, while a capture is under way.
    wire accept = lnk.req && st_q == ST_IDLE; // R16
    wire refuse = lnk.req && st_q != ST_IDLE; // R16

    // Link B timing leads only in single-link mode with link B chosen.
    wire use_b = !cfg_q.dual && cur_link_q; // R2
    wire s_valid = use_b ? b_valid_i : a_valid_i; // R1
    wire s_fs = use_b ? b_fs_i : a_fs_i;
    wire s_ls = use_b ? b_ls_i : a_ls_i;
    wire [PXW-1:0] s_pix = cfg_q.dual ? {a_data_i[PXW-1:ALPHA_W], b_data_i[ALPHA_W-1:0]} // R3
                                      : (use_b ? b_data_i : a_data_i); // R2

    // Overall ratio per axis is decimation times aspect, kept as a fraction.
    wire [ACW-1:0] h_num = ACW'(cfg_q.dec_num) * ACW'(cfg_q.h_num);
    wire [ACW-1:0] h_den = ACW'(cfg_q.dec_den) * ACW'(cfg_q.h_den);
    wire [ACW-1:0] v_num = ACW'(cfg_q.dec_num) * ACW'(cfg_q.v_num);
    wire [ACW-1:0] v_den = ACW'(cfg_q.dec_den) * ACW'(cfg_q.v_den);
    wire [ACW-1:0] h_acc = hacc_q + h_num;
    wire [ACW-1:0] v_acc = vacc_q + v_num;
    wire h_emit = h_acc >= h_den; // R5
    wire v_emit = v_acc >= v_den; // R5
    wire [CW-1:0] ry_n = ry_q + CW'(1);
    wire line_in = ry_n >= cfg_q.off_y; // R5
    wire px_in = s_valid && line_ok_q && rx_q >= cfg_q.off_x; // R5

    // In pyramid mode the size control is overridden by the buffer shape, which is level zero by default.
    wire [XW:0] w_cap = cfg_q.size_w > CW'(BUF_W) ? (XW+1)'(BUF_W) : cfg_q.size_w[XW:0];
    wire [YW:0] h_cap = cfg_q.size_h > CW'(BUF_H) ? (YW+1)'(BUF_H) : cfg_q.size_h[YW:0];
    wire [XW:0] w_lim = cfg_q.pyramid ? (XW+1)'(BUF_W) : w_cap; // R12
    wire [YW:0] h_lim = cfg_q.pyramid ? (YW+1)'(BUF_H) : h_cap; // R12
    wire fill_we = st_q == ST_FILL && px_in && h_emit && ox_q < CW'(w_lim); // R6
    wire [AYW+AXW-1:0] wr_addr = {oy_q[AYW-1:0], ox_q[AXW-1:0]};

    // Each level halves both sides, but never below one texel.
    wire [XW:0] lw_raw = w_lim >> lvl_q;
    wire [YW:0] lh_raw = h_lim >> lvl_q;
    wire [XW:0] lw = lw_raw == '0 ? (XW+1)'(1) : lw_raw; // R12
    wire [YW:0] lh = lh_raw == '0 ? (YW+1)'(1) : lh_raw; // R12
    wire x_end = {1'b0, dx_q} == lw - (XW+1)'(1);
    wire y_end = {1'b0, dy_q} == lh - (YW+1)'(1);
    wire l_end = !cfg_q.pyramid || lvl_q == LW'(LEVELS - 1); // R11
    wire [XW-1:0] sx = dx_q << lvl_q;
    wire [YW-1:0] sy = dy_q << lvl_q;
    wire [AYW+AXW-1:0] rd_addr = {sy[AYW-1:0], sx[AXW-1:0]};
    wire slot = !tmv_q || lnk.tm_ready;
    wire issue = st_q == ST_DRAIN && !last_q && slot;
    wire finish = st_q == ST_DRAIN && last_q && slot;

    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: begin
                if (accept) begin
                    st_d = ST_ARM;
                end
            end
            ST_ARM: begin
                if (s_fs) begin
                    st_d = ST_FILL; // R14
                end
            end
            ST_FILL: begin
                if (s_fs) begin
                    st_d = ST_DRAIN; // R14
                end
            end
            ST_DRAIN: begin
                if (finish) begin
                    st_d = ST_IDLE;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= ST_IDLE;
            ack_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            missed_q <= 1'b0;
        end else begin
            st_q <= st_d;
            ack_q <= accept; // R7
            busy_q <= st_d != ST_IDLE; // R16
            done_q <= finish; // R15
            missed_q <= refuse; // R15
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_q <= CFG_RST;
            buf_q <= 1'b0;
            cur_link_q <= 1'b0;
        end else if (accept) begin
            cfg_q <= lnk.cfg;
            buf_q <= lnk.req_buf;
            if (!lnk.cfg.alt_en) begin
                cur_link_q <= lnk.cfg.link_sel; // R2
            end
        end else if (finish && cfg_q.alt_en && !cfg_q.dual) begin
            cur_link_q <= !cur_link_q; // R4
        end
    end

    // Raw position counters; the line strobe precedes the first pixel of each line.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_q <= '0;
            ry_q <= '0;
            ox_q <= '0;
            oy_q <= '0;
            nline_q <= '0;
            line_ok_q <= 1'b0;
            hacc_q <= '0;
            vacc_q <= '0;
        end else if (s_fs) begin
            ry_q <= '1;
            nline_q <= '0;
            vacc_q <= '0;
            line_ok_q <= 1'b0;
        end else if (s_ls) begin
            rx_q <= '0;
            ry_q <= ry_n;
            ox_q <= '0;
            hacc_q <= '0;
            if (line_in) begin
                vacc_q <= v_emit ? v_acc - v_den : v_acc; // R5
                line_ok_q <= v_emit && nline_q < CW'(h_lim);
                if (v_emit) begin
                    oy_q <= nline_q;
                    nline_q <= nline_q + CW'(1);
                end
            end else begin
                line_ok_q <= 1'b0;
            end
        end else if (s_valid) begin
            rx_q <= rx_q + CW'(1);
            if (px_in) begin
                hacc_q <= h_emit ? h_acc - h_den : h_acc; // R5
                ox_q <= h_emit ? ox_q + CW'(1) : ox_q;
            end
        end
    end

    // Pixels outside a requested field simply never reach the buffer.
    always_ff @(posedge mclk_i) begin
        if (fill_we) begin
            fbuf[wr_addr] <= s_pix; // R6
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tmv_q <= 1'b0;
            last_q <= 1'b0;
            lvl_q <= '0;
            dx_q <= '0;
            dy_q <= '0;
            tm_lvl_q <= '0;
            tm_x_q <= '0;
            tm_y_q <= '0;
            tm_data_q <= '0;
        end else if (st_q == ST_FILL && s_fs) begin
            lvl_q <= '0;
            dx_q <= '0;
            dy_q <= '0;
            last_q <= 1'b0;
        end else if (issue) begin
            tmv_q <= 1'b1;
            tm_data_q <= fbuf[rd_addr]; // R11
            tm_lvl_q <= lvl_q;
            tm_x_q <= dx_q;
            tm_y_q <= dy_q;
            dx_q <= x_end ? '0 : dx_q + XW'(1);
            if (x_end) begin
                dy_q <= y_end ? '0 : dy_q + YW'(1);
                if (y_end && l_end) begin
                    last_q <= 1'b1;
                end else if (y_end) begin
                    lvl_q <= lvl_q + LW'(1); // R11
                end
            end
        end else if (slot) begin
            tmv_q <= 1'b0;
            if (finish) begin
                last_q <= 1'b0;
            end
        end
    end

    assign lnk.ack = ack_q;
    assign lnk.busy = busy_q;
    assign lnk.done_ev = done_q;
    assign lnk.missed_ev = missed_q;
    assign lnk.cur_link = cur_link_q;
    assign lnk.tm_valid = tmv_q;
    assign lnk.tm_buf = buf_q;
    assign lnk.tm_level = tm_lvl_q;
    assign lnk.tm_x = tm_x_q;
    assign lnk.tm_y = tm_y_q;
    assign lnk.tm_data = tm_data_q;
endmodule
`default_nettype wire

// >>> hw/vtc_host.sv
`timescale 1ns/1ns
`default_nettype none
module vtc_host import vtc_pkg::*; #(
    parameter longint TEX_MEM_BYTES = TEX_MEM_MIN_BYTES
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    vtc_if.host lnk,
    input wire vtc_cfg_t cfg_i,
    input wire logic [RW-1:0] field_w_i,
    input wire logic [RW-1:0] field_h_i,
    input wire logic double_buffer_i,
    input wire logic capture_i,
    input wire logic read_start_i,
    input wire logic read_end_i,
    input wire logic mem_ready_i,
    output logic busy_o,
    output logic [1:0] loaded_o,
    output logic reading_o,
    output logic read_buf_o,
    output logic done_o,
    output logic missed_o,
    output logic mem_we_o,
    output logic mem_buf_o,
    output logic [LW-1:0] mem_level_o,
    output logic [XW-1:0] mem_x_o,
    output logic [YW-1:0] mem_y_o,
    output logic [PXW-1:0] mem_data_o
);
    vtc_cfg_t cfg_d;
    vtc_cfg_t cfg_q;
    logic req_q;
    logic req_buf_q;
    logic nxt_q;
    logic cap_buf_q;
    logic last_buf_q;
    logic tm_ready_q;

    // A small texture memory silently falls back to a single buffer.
    wire dbl = double_buffer_i && TEX_MEM_BYTES >= TEX_MEM_MIN_BYTES; // R10
    wire tgt = dbl ? nxt_q : 1'b0; // R9
    wire tgt_free = !(reading_o && read_buf_o == tgt); // R8
    // Requests are passed on while busy too, so that the device reports a capture missed while busy unless its target buffer is being read.
    wire go = capture_i && !req_q && tgt_free; // R15
    wire grant = read_start_i && !reading_o && loaded_o[last_buf_q]; // R8
    wire clr = reading_o && read_end_i;
    wire [RW-1:0] v_den = field_h_i > RW'(LVL0_H) ? field_h_i : RW'(LVL0_H);

    always_comb begin
        cfg_d = cfg_i;
        if (cfg_i.pyramid) begin
            cfg_d.dec_num = DW'(1); // R13
            cfg_d.dec_den = DW'(1); // R13
            cfg_d.h_num = RW'(LVL0_W); // R13
            cfg_d.h_den = field_w_i; // R13
            cfg_d.v_num = RW'(LVL0_H); // R13
            cfg_d.v_den = v_den; // R13
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_q <= CFG_RST;
            req_q <= 1'b0;
            req_buf_q <= 1'b0;
            nxt_q <= 1'b0;
            cap_buf_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            req_q <= go;
            if (go) begin
                req_buf_q <= tgt;
            end
            // A refused request must not steal the buffer of the capture under way.
            if (lnk.ack) begin
                cap_buf_q <= req_buf_q;
                nxt_q <= !nxt_q; // R9
            end
        end
    end

    // A load completing on the same edge as a read ending keeps its loaded flag.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            loaded_o <= '0;
            reading_o <= 1'b0;
            read_buf_o <= 1'b0;
            last_buf_q <= 1'b0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (lnk.done_ev && cap_buf_q == 1'(i)) begin
                    loaded_o[i] <= 1'b1; // R8
                end else if (clr && read_buf_o == 1'(i)) begin
                    loaded_o[i] <= 1'b0;
                end
            end
            if (lnk.done_ev) begin
                last_buf_q <= cap_buf_q;
            end
            if (grant) begin
                reading_o <= 1'b1;
                read_buf_o <= last_buf_q;
            end else if (clr) begin
                reading_o <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tm_ready_q <= 1'b0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
            missed_o <= 1'b0;
            mem_we_o <= 1'b0;
            mem_buf_o <= 1'b0;
            mem_level_o <= '0;
            mem_x_o <= '0;
            mem_y_o <= '0;
            mem_data_o <= '0;
        end else begin
            tm_ready_q <= mem_ready_i;
            busy_o <= lnk.busy;
            done_o <= lnk.done_ev;
            missed_o <= lnk.missed_ev;
            mem_we_o <= lnk.tm_valid && tm_ready_q;
            mem_buf_o <= lnk.tm_buf;
            mem_level_o <= lnk.tm_level;
            mem_x_o <= lnk.tm_x;
            mem_y_o <= lnk.tm_y;
            mem_data_o <= lnk.tm_data;
        end
    end

    assign lnk.req = req_q;
    assign lnk.req_buf = req_buf_q;
    assign lnk.cfg = cfg_q;
    assign lnk.tm_ready = tm_ready_q;
endmodule
`default_nettype wire

// >>> tb/vtc_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module vtc_monitor import vtc_pkg::*; (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic req,
    input wire logic ack,
    input wire logic busy,
    input wire logic done_ev,
    input wire logic missed_ev,
    input wire logic tm_valid,
    input wire logic tm_ready,
    input wire logic [LW-1:0] tm_level,
    input wire logic [XW-1:0] tm_x,
    input wire logic [YW-1:0] tm_y,
    input wire logic [PXW-1:0] tm_data
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    a_req_acked: assert property (req && !busy |=> ack && busy)
        else $error("idle request not acknowledged");
    a_busy_refused: assert property (req && busy |=> missed_ev && !ack)
        else $error("request while busy not refused");
    a_ack_caused: assert property (ack |-> $past(req))
        else $error("acknowledge without request");
    a_texel_held: assert property (tm_valid && !tm_ready |=> tm_valid && $stable({tm_level, tm_x, tm_y, tm_data}))
        else $error("stalled texel changed");
    a_idle_quiet: assert property (!busy |-> !tm_valid)
        else $error("texel written with no capture");
    a_level_bound: assert property (tm_valid |-> tm_level < LVL_COUNT)
        else $error("level out of range");
    a_level_shape: assert property (tm_valid |-> (tm_x >> (XW - tm_level)) == 0 &&
        (tm_y >> (tm_level > YW ? 0 : YW - tm_level)) == 0)
        else $error("texel outside level size");
    a_done_caused: assert property (done_ev |-> $past(tm_valid && tm_ready) && !busy)
        else $error("done without last accept");
    a_busy_ends: assert property ($fell(busy) |-> done_ev)
        else $error("busy dropped without done");

    c_accept: cover property (req && !busy ##1 ack);
    c_stall: cover property (tm_valid && !tm_ready);
    c_done: cover property (done_ev);
    c_refuse: cover property (req && busy ##1 missed_ev);
endmodule
`default_nettype wire

// >>> tb/test_video_texture_capture.sv
`timescale 1ns/1ns
`default_nettype none
module test_video_texture_capture import vtc_pkg::*;;
    typedef struct packed {
        logic sel;
        logic alt;
        logic dual;
        logic dup;
        logic [1:0] hd;
        logic [1:0] vd;
        logic stall;
        logic [1:0] lnk;
    } vtc_row_t;

    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    vtc_cfg_t cfg = CFG_RST;
    logic [RW-1:0] fw = 12'h010;
    logic [RW-1:0] fh = 12'h008;
    logic dbl = 1'b0, cap = 1'b0, rd_s = 1'b0, rd_e = 1'b0, mrdy = 1'b1, stall = 1'b0;
    logic vval = 1'b0, vfs = 1'b0, vls = 1'b0;
    logic [PXW-1:0] adat = 32'h0, bdat = 32'h0;
    logic busy, rdg, rbuf, done, we, mbuf, missed;
    int nmiss = 0;
    logic [1:0] loaded;
    logic [LW-1:0] mlvl;
    logic [XW-1:0] mx;
    logic [YW-1:0] my;
    logic [PXW-1:0] mdat;
    logic [53:0] q[$];
    int mismatches = 0;
    int tests_run = 0;
    vtc_row_t rows[7] = '{'{0, 0, 0, 0, 1, 1, 0, 0}, '{1, 0, 0, 0, 1, 1, 0, 1}, '{0, 0, 1, 0, 1, 1, 0, 2},
        '{0, 0, 0, 1, 2, 1, 0, 0}, '{1, 0, 0, 0, 1, 2, 1, 1}, '{1, 1, 0, 0, 1, 1, 0, 1}, '{0, 1, 0, 0, 1, 1, 0, 0}};

    always #4 mclk_i = ~mclk_i;

    vtc_if lnk_if();
    vtc_dev #(.BUF_W(16), .BUF_H(8), .LEVELS(5)) i_vtc_dev(.mclk_i(mclk_i), .rst_n_i(rst_n_i), .lnk(lnk_if),
        .a_valid_i(vval), .a_fs_i(vfs), .a_ls_i(vls), .a_data_i(adat),
        .b_valid_i(vval), .b_fs_i(vfs), .b_ls_i(vls), .b_data_i(bdat));
    vtc_host i_vtc_host(.mclk_i(mclk_i), .rst_n_i(rst_n_i), .lnk(lnk_if), .cfg_i(cfg), .field_w_i(fw),
        .field_h_i(fh), .double_buffer_i(dbl), .capture_i(cap), .read_start_i(rd_s), .read_end_i(rd_e),
        .mem_ready_i(mrdy), .busy_o(busy), .loaded_o(loaded), .reading_o(rdg), .read_buf_o(rbuf),
        .done_o(done), .missed_o(missed), .mem_we_o(we), .mem_buf_o(mbuf), .mem_level_o(mlvl), .mem_x_o(mx),
        .mem_y_o(my), .mem_data_o(mdat));
    vtc_monitor i_vtc_monitor(.mclk_i(mclk_i), .rst_n_i(rst_n_i), .req(lnk_if.req), .ack(lnk_if.ack),
        .busy(lnk_if.busy), .done_ev(lnk_if.done_ev), .missed_ev(lnk_if.missed_ev), .tm_valid(lnk_if.tm_valid),
        .tm_ready(lnk_if.tm_ready), .tm_level(lnk_if.tm_level), .tm_x(lnk_if.tm_x), .tm_y(lnk_if.tm_y),
        .tm_data(lnk_if.tm_data));

    // The memory side takes every write, so a stall only slows the drain.
    always @(negedge mclk_i) mrdy <= stall ? ~mrdy : 1'b1;
    always @(negedge mclk_i) if (we === 1'b1) q.push_back({mbuf, mlvl, mx, my, mdat});
    always @(negedge mclk_i) if (missed === 1'b1) nmiss++;

    function automatic logic [PXW-1:0] pix(input logic l, input int x, input int y);
        return {l ? 8'hB1 : 8'hA1, 8'(y), 8'(x), l ? 8'hB2 : 8'hA2};
    endfunction

    task automatic cmp(input string nm, input logic [63:0] e, input logic [63:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic pulse(ref logic s);
        @(negedge mclk_i) s = 1'b1;
        @(negedge mclk_i) s = 1'b0;
    endtask

    task automatic field(input int w, input int h);
        @(negedge mclk_i) vfs = 1'b1;
        for (int y = 0; y < h; y++) begin
            @(negedge mclk_i) {vfs, vls, vval} = 3'b010;
            for (int x = 0; x < w; x++) begin
                @(negedge mclk_i) {vls, vval} = 2'b01;
                adat = pix(1'b0, x, y);
                bdat = pix(1'b1, x, y);
            end
        end
        @(negedge mclk_i) {vfs, vls, vval} = 3'b000;
    endtask

    // The second field only supplies the start that closes the fill.
    task automatic capture(input int w, input int h, input logic dup);
        q.delete();
        pulse(cap);
        repeat (3) @(negedge mclk_i);
        if (dup) pulse(cap);
        field(w, h);
        field(4, 1);
        for (int i = 0; i < 4000 && done !== 1'b1; i++) @(negedge mclk_i);
        cmp("done", 1, done);
        repeat (2) @(negedge mclk_i);
    endtask

    initial begin
        repeat (60000) @(posedge mclk_i);
        mismatches++;
        conclude();
    end

    initial begin
        int sx, sy, m0, n, lw, lh;
        logic [PXW-1:0] ea, eb, ed;
        {cfg.size_w, cfg.size_h, cfg.off_x, cfg.off_y} = {12'h010, 12'h008, 12'h002, 12'h002};
        repeat (12) @(negedge mclk_i);
        rst_n_i = 1'b1;
        foreach (rows[r]) begin
            {cfg.link_sel, cfg.alt_en, cfg.dual} = {rows[r].sel, rows[r].alt, rows[r].dual};
            cfg.h_den = 12'(rows[r].hd);
            cfg.v_den = 12'(rows[r].vd);
            stall = rows[r].stall;
            m0 = nmiss;
            capture(2 + 16 * rows[r].hd, 2 + 8 * rows[r].vd, rows[r].dup);
            cmp("count", 128, q.size());
            cmp("missed", rows[r].dup, nmiss - m0);
            foreach (q[i]) begin
                sx = 1 + (i % 16 + 1) * rows[r].hd;
                sy = 1 + (i / 16 + 1) * rows[r].vd;
                ea = pix(1'b0, sx, sy);
                eb = pix(1'b1, sx, sy);
                ed = (rows[r].lnk == 2'd2) ? {ea[31:8], eb[7:0]} : (rows[r].lnk[0] ? eb : ea);
                cmp("texel", {5'h00, 9'(i % 16), 8'(i / 16), ed}, q[i]);
            end
            $display("row %0d finished", r);
        end
        cmp("cur_link", 1, lnk_if.cur_link);
        pulse(rd_s);
        cmp("reading", 2'b10, {rdg, rbuf});
        pulse(cap);
        repeat (20) @(negedge mclk_i);
        cmp("blocked busy", 0, busy);
        pulse(rd_e);
        cmp("loaded", 0, loaded);
        $display("single buffer test finished");
        pulse(cap);
        repeat (4) @(negedge mclk_i);
        cmp("busy", 1, busy);
        rst_n_i = 1'b0;
        @(negedge mclk_i);
        cmp("reset outputs", 0, {busy, done, missed, loaded, we, rdg});
        rst_n_i = 1'b1;
        $display("reset test finished");
        dbl = 1'b1;
        cfg.alt_en = 1'b0;
        for (int k = 0; k < 2; k++) begin
            capture(18, 10, 1'b0);
            cmp("buffer", k, q[0][53]);
        end
        cmp("loaded", 2'b11, loaded);
        pulse(rd_s);
        cmp("read buffer", 2'b11, {rdg, rbuf});
        capture(18, 10, 1'b0);
        cmp("buffer", 0, q[0][53]);
        $display("double buffer test finished");
        // Every pixel is kept, so level l texel (x,y) is the field pixel at (x<<l, y<<l) past the offset.
        pulse(rd_e);
        {cfg.pyramid, cfg.h_den, cfg.size_w, cfg.size_h} = {1'b1, 12'h003, 12'h004, 12'h003};
        {fw, fh} = {12'h012, 12'h00A};
        capture(18, 10, 1'b0);
        n = 0;
        for (int l = 0; l < 5; l++) begin
            lw = 16 >> l;
            lh = (8 >> l) == 0 ? 1 : 8 >> l;
            for (int y = 0; y < lh; y++) begin
                for (int x = 0; x < lw; x++) begin
                    ed = pix(1'b0, 2 + (x << l), 2 + (y << l));
                    cmp("level texel", {1'b1, 4'(l), 9'(x), 8'(y), ed}, q[n]);
                    n++;
                end
            end
        end
        cmp("level count", 171, q.size());
        $display("level pyramid test finished");
        conclude();
    end
endmodule
`default_nettype wire
